// >>> core/gaa_annunciator.sv
// Genset alarm annunciator with shutdown actions and AXI4-Lite registers
`default_nettype none
module gaa_annunciator
  import gaa_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Field inputs
  input wire logic [N_POINTS-1:0] fault_in,
  input wire logic [N_POINTS-1:0] sensor_ok_in,
  input wire logic ack_in,
  input wire logic reset_in,
  input wire logic lamp_test_in,
  // Annunciation and actions
  output gaa_lamp_type lamp,
  output gaa_alarm_out_type alarm_out,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [N_IN-1:0] raw;
  logic [N_IN-1:0] clean;
  logic [N_POINTS-1:0] cond;
  logic [N_POINTS-1:0] cond_d_r;
  logic [N_POINTS-1:0] new_ev;
  logic [N_POINTS-1:0] active_r;
  logic [N_POINTS-1:0] active_nxt;
  logic [N_POINTS-1:0] unack_r;
  logic [N_POINTS-1:0] unack_nxt;
  logic [N_POINTS-1:0] class_r;
  logic [N_POINTS-1:0] vis;
  logic ack_d_r;
  logic rst_d_r;
  logic ack_ev;
  logic rst_ev;
  logic sw_ack_r;
  logic sw_rst_r;
  logic test_r;
  logic test_on;
  logic [31:0] flash_cnt_r;
  logic flash_tick;
  logic flash_r;
  logic flash_nxt;
  gaa_lamp_type lamp_r;
  gaa_alarm_out_type out_r;
  // Bus side
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic do_wr;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [DATA_W-1:0] rdata_r;

  assign raw = {lamp_test_in, reset_in, ack_in, sensor_ok_in, fault_in};

  // One filter per input; sensor-good lines idle high so reset shows no loss
  for (genvar i = 0; i < N_IN; i++)
  begin : g_in
    gaa_debounce #(
      .CYC(DEBOUNCE_CYCLES),
      .RST_VAL((i >= IDX_SENS) && (i < IDX_ACK))
    ) u_db (
      .clk(clk),
      .srst(srst),
      .din(raw[i]),
      .dout(clean[i])
    );
  end

  // A lost sensor counts as a fault on its point
  assign cond = clean[IDX_FAULT +: N_POINTS] | ~clean[IDX_SENS +: N_POINTS];
  assign new_ev = cond & ~cond_d_r;
  assign ack_ev = (clean[IDX_ACK] & ~ack_d_r) | sw_ack_r;
  assign rst_ev = (clean[IDX_RST] & ~rst_d_r) | sw_rst_r;
  assign test_on = clean[IDX_TEST] | test_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cond_d_r <= '0;
      ack_d_r <= 1'b0;
      rst_d_r <= 1'b0;
    end
    else
    begin
      cond_d_r <= cond;
      ack_d_r <= clean[IDX_ACK];
      rst_d_r <= clean[IDX_RST];
    end
  end

  // Common flash clock so every lamp blinks in phase
  assign flash_tick = (flash_cnt_r == 32'(FLASH_CYCLES - 1));
  assign flash_nxt = flash_r ^ flash_tick;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flash_cnt_r <= 32'h0;
      flash_r <= 1'b1;
    end
    else
    begin
      flash_cnt_r <= flash_tick ? 32'h0 : flash_cnt_r + 32'h1;
      flash_r <= flash_nxt;
    end
  end

  // Latch holds while the condition persists; reset only clears a normal point
  assign active_nxt = cond | (active_r & ~{N_POINTS{rst_ev}});
  // A fresh event beats a simultaneous acknowledge
  assign unack_nxt = new_ev | (unack_r & ~{N_POINTS{ack_ev}} & active_nxt);
  assign vis = active_nxt & (~unack_nxt | {N_POINTS{flash_nxt}});

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      active_r <= '0;
      unack_r <= '0;
    end
    else
    begin
      active_r <= active_nxt;
      unack_r <= unack_nxt;
    end
  end

  // Outputs are taken from the same next-state terms so they rise together
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lamp_r <= '0;
      out_r <= '0;
    end
    else
    begin
      lamp_r.red <= test_on ? '1 : (vis & class_r);
      lamp_r.amber <= test_on ? '1 : (vis & ~class_r);
      out_r.horn <= test_on | (|unack_nxt);
      out_r.engine_stop <= |(active_nxt & class_r);
      out_r.breaker_open <= |(active_nxt & class_r);
      out_r.common_local <= |active_nxt;
      out_r.common_remote <= |active_nxt;
    end
  end

  assign lamp = lamp_r;
  assign alarm_out = out_r;

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign aw_have = aw_got_r || s_axi_awvalid;
  assign w_have = w_got_r || s_axi_wvalid;
  assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
  assign do_wr = !bvalid_r && aw_have && w_have;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else if (do_wr)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_addr <= OFF_OUTS && wr_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Software control; ack and reset bits are self-clearing pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      test_r <= CTRL_TEST_RST;
      class_r <= CLASS_RST;
      sw_ack_r <= 1'b0;
      sw_rst_r <= 1'b0;
    end
    else
    begin
      sw_ack_r <= 1'b0;
      sw_rst_r <= 1'b0;
      if (do_wr && wr_strb[0] && wr_addr == OFF_CTRL)
      begin
        test_r <= wr_data[CTRL_TEST_BIT];
        sw_ack_r <= wr_data[CTRL_ACK_BIT];
        sw_rst_r <= wr_data[CTRL_RST_BIT];
      end
      if (do_wr && wr_strb[0] && wr_addr == OFF_CLASS)
        class_r <= wr_data[N_POINTS-1:0];
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Read channel: one-cycle registered answer
  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      unique case (s_axi_araddr)
        OFF_CTRL: rdata_r[CTRL_TEST_BIT] <= test_r;
        OFF_CLASS: rdata_r[N_POINTS-1:0] <= class_r;
        OFF_ACTIVE: rdata_r[N_POINTS-1:0] <= active_r;
        OFF_UNACK: rdata_r[N_POINTS-1:0] <= unack_r;
        OFF_SFAIL: rdata_r[N_POINTS-1:0] <= ~clean[IDX_SENS +: N_POINTS];
        OFF_OUTS: rdata_r[4:0] <= out_r;
        default: rresp_r <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_HORN_UNACK: assert property ((|unack_r) |-> out_r.horn)
    else $error("horn off with alarm unacknowledged");
  AST_ACK_SILENCE: assert property ((ack_ev && !(|new_ev) && !test_on) |=> !out_r.horn)
    else $error("horn still on after acknowledge");
  AST_REARM: assert property ((|new_ev) |=> ($past(new_ev) & ~unack_r) == '0)
    else $error("new alarm not marked unacknowledged");
  AST_SHUT_SAME: assert property ((|(new_ev & class_r))
    |=> out_r.engine_stop && out_r.breaker_open && out_r.horn)
    else $error("shutdown outputs not raised together");
  AST_STOP_CAUSE: assert property (out_r.engine_stop |-> out_r.breaker_open && (|(active_r & $past(class_r))))
    else $error("stop without active shutdown point");
  AST_PROBLEM_ONLY: assert property (((active_r & $past(class_r)) == '0) |-> !out_r.engine_stop)
    else $error("problem alarm caused a stop");
  AST_LATCH_HOLD: assert property ((|(active_r & cond)) |=> ($past(active_r & cond) & ~active_r) == '0)
    else $error("latched alarm cleared while fault present");
  AST_STEADY: assert property ((!test_on && $stable(class_r))
    |=> ((active_r & ~unack_r) & ~(lamp.red | lamp.amber)) == '0)
    else $error("acknowledged lamp not steady");
  AST_RED_CLASS: assert property ((!$past(test_on) && $stable(class_r)) |-> (lamp.red & ~class_r) == '0)
    else $error("red lamp on a problem point");
  AST_FLASH_RATE: assert property ($changed(flash_r) |-> $past(flash_cnt_r) == 32'(FLASH_CYCLES - 1))
    else $error("flash toggled off schedule");
  AST_TEST: assert property (test_on |=> lamp.red == '1 && lamp.amber == '1 && out_r.horn)
    else $error("self-test did not light all indications");
  AST_COMMON: assert property (out_r.common_local == (|active_r) && out_r.common_remote == (|active_r))
    else $error("common contacts disagree with alarms");

  COV_SHUTDOWN: cover property ((|(new_ev & class_r)) ##1 out_r.engine_stop);
  COV_ACK: cover property ((|unack_r) ##1 ack_ev ##1 !out_r.horn);
  COV_CLEAR: cover property ((|active_r) ##1 rst_ev ##1 (active_r == '0));
  COV_TEST: cover property (test_on ##1 (lamp.red == '1));
endmodule : gaa_annunciator
`default_nettype wire

// >>> core/gaa_pkg.sv
// Constants and types shared by the genset alarm annunciator
`default_nettype none
package gaa_pkg;
  localparam int N_POINTS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLASS = 8'h04;
  localparam logic [7:0] OFF_ACTIVE = 8'h08;
  localparam logic [7:0] OFF_UNACK = 8'h0c;
  localparam logic [7:0] OFF_SFAIL = 8'h10;
  localparam logic [7:0] OFF_OUTS = 8'h14;
  // Control bits
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  // Reset values
  localparam logic CTRL_TEST_RST = 1'h0;
  localparam logic [7:0] CLASS_RST = 8'h0f;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC = FLASH_HALF_MS * CLK_KHZ;
  // Debounced input vector layout
  localparam int IDX_FAULT = 0;
  localparam int IDX_SENS = 8;
  localparam int IDX_ACK = 16;
  localparam int IDX_RST = 17;
  localparam int IDX_TEST = 18;
  localparam int N_IN = 19;

  typedef struct packed {
    logic horn;
    logic engine_stop;
    logic breaker_open;
    logic common_local;
    logic common_remote;
  } gaa_alarm_out_type;

  typedef struct packed {
    logic [N_POINTS-1:0] red;
    logic [N_POINTS-1:0] amber;
  } gaa_lamp_type;
endpackage : gaa_pkg
`default_nettype wire

// >>> core/gaa_debounce.sv
// Two-stage synchroniser with a stability-count debouncer
`default_nettype none
module gaa_debounce
  import gaa_pkg::*;
#(
  parameter int unsigned CYC = DEBOUNCE_CYC,
  parameter logic RST_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw and clean level
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic dout_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  // Output moves only after the input held steady for CYC cycles
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r <= 32'h0;
      dout_r <= RST_VAL;
    end
    else if (s2_r == dout_r)
      cnt_r <= 32'h0;
    else if (cnt_r >= 32'(CYC - 1))
    begin
      cnt_r <= 32'h0;
      dout_r <= s2_r;
    end
    else
      cnt_r <= cnt_r + 32'h1;
  end

  assign dout = dout_r;
endmodule : gaa_debounce
`default_nettype wire

// >>> verification/gaa_panel_model.sv
// Operator panel and field sensor model driving the annunciator pins
`default_nettype none
module gaa_panel_model
#(
  parameter int PRESS = 8
)
(
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic [7:0] fault_set,
  input wire logic [7:0] sens_set,
  input wire logic test_set,
  input wire logic ack_go,
  input wire logic rst_go,
  // Field pins
  output logic [7:0] fault_in,
  output logic [7:0] sensor_ok_in,
  output logic ack_in,
  output logic reset_in,
  output logic lamp_test_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int ack_cnt = 0;
  int rst_cnt = 0;
  // Each press is a discrete request held long enough to pass the debouncer
  // Pins stay unknown until the first edge, which the design's reset covers
  always @(posedge clk)
  begin
    ack_cnt <= ack_go ? PRESS : (ack_cnt > 0 ? ack_cnt - 1 : 0);
    rst_cnt <= rst_go ? PRESS : (rst_cnt > 0 ? rst_cnt - 1 : 0);
    ack_in <= ack_cnt > 0;
    reset_in <= rst_cnt > 0;
    fault_in <= fault_set;
    sensor_ok_in <= sens_set;
    lamp_test_in <= test_set;
  end
endmodule : gaa_panel_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the genset alarm annunciator
`default_nettype none
module testbench
  import gaa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 14;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] fault_set = 8'h00, sens_set = 8'hff, fault_in, sensor_ok_in;
  logic test_set = 1'b0, ack_go = 1'b0, rst_go = 1'b0, ack_in, reset_in, lamp_test_in;
  gaa_lamp_type lamp;
  gaa_alarm_out_type alarm_out;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic [7:0] act, un, cls;
  int mismatches = 0;
  int checks = 0;
  int p;
  initial
  begin
    forever #2 clk = ~clk;
  end
  gaa_panel_model #(.PRESS(8)) panel_u (.clk(clk), .fault_set(fault_set), .sens_set(sens_set),
    .test_set(test_set), .ack_go(ack_go), .rst_go(rst_go), .fault_in(fault_in),
    .sensor_ok_in(sensor_ok_in), .ack_in(ack_in), .reset_in(reset_in), .lamp_test_in(lamp_test_in));
  gaa_annunciator #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8)) dut_u (.clk(clk), .srst(srst),
    .fault_in(fault_in), .sensor_ok_in(sensor_ok_in), .ack_in(ack_in), .reset_in(reset_in),
    .lamp_test_in(lamp_test_in), .lamp(lamp), .alarm_out(alarm_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [4:0] eo(input logic [7:0] a, input logic [7:0] u, input logic [7:0] c);
    return {|u, |(a & c), |(a & c), |a, |a};
  endfunction : eo
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic co();
    @(negedge clk);
    chk("alarm_out", {27'h0, eo(act, un, cls)}, {27'h0, alarm_out});
  endtask : co
  // Flashing bits must both toggle and agree with each other
  task automatic cl();
    logic [15:0] m, fm, o, a, f;
    logic ph;
    m = {act & cls, act & ~cls};
    fm = {un & cls, un & ~cls};
    o = 16'h0;
    a = 16'hffff;
    ph = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      o = o | lamp;
      a = a & lamp;
      f = lamp & fm;
      ph = ph | (f !== 16'h0 && f !== fm);
    end
    chk("lamp_lit", {16'h0, m}, {16'h0, o});
    chk("lamp_steady", {16'h0, m & ~fm}, {16'h0, a});
    chk("flash_phase", 0, {31'h0, ph});
  endtask : cl
  task automatic axw(input logic [7:0] ad, input logic [31:0] dv, output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= ad;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    // Only bvalid ends this wait; a hang is left to the watchdog
    while (!tb)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid === 1'b1;
      rs = bresp;
      // Response must follow both address and data
      if (tb)
        chk("b_after_aw_w", 0, {30'h0, awvalid, wvalid});
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rs);
    logic ta, tr;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid === 1'b1;
      dv = rdata;
      rs = rresp;
      if (tr)
        chk("r_after_ar", 0, {31'h0, arvalid});
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  task automatic press(input logic is_ack);
    @(posedge clk);
    ack_go <= is_ack;
    rst_go <= ~is_ack;
    @(posedge clk);
    ack_go <= 1'b0;
    rst_go <= 1'b0;
    cyc(8 + ST);
  endtask : press
  initial
  begin
    #80000;
    mismatches++;
    $display("timeout");
    results();
  end
  initial
  begin
    void'($urandom(32'h356bc1c0));
    act = 8'h0;
    un = 8'h0;
    cls = CLASS_RST;
    cyc(10);
    srst <= 1'b0;
    cyc(2);
    co();
    axr(OFF_CLASS, d, r);
    chk("class_reset", {24'h0, CLASS_RST}, d);
    // Two-cycle glitch is shorter than the stability span
    @(posedge clk);
    fault_set <= 8'h01;
    cyc(2);
    fault_set <= 8'h00;
    cyc(ST);
    co();
    $display("test reset_glitch done");
    p = $urandom % 4;
    act = 8'h1 << p;
    un = act;
    fault_set <= act;
    cyc(ST);
    co();
    cl();
    press(1'b1);
    un = 8'h0;
    co();
    cl();
    press(1'b0);
    co();
    fault_set <= 8'h00;
    cyc(ST);
    co();
    press(1'b0);
    act = 8'h0;
    co();
    $display("test shutdown done");
    p = 4 + $urandom % 4;
    act = 8'h1 << p;
    un = act;
    fault_set <= act;
    cyc(ST);
    co();
    cl();
    axw(OFF_CTRL, 32'h1 << CTRL_ACK_BIT, r);
    cyc(4);
    un = 8'h0;
    co();
    p = 4 + (p - 3) % 4;
    un = 8'h1 << p;
    act = act | un;
    fault_set <= act;
    cyc(ST);
    co();
    cl();
    $display("test problem done");
    p = $urandom % 8;
    fault_set <= 8'h00;
    sens_set <= ~(8'h1 << p);
    act = act | (8'h1 << p);
    un = un | (8'h1 << p);
    cyc(ST);
    co();
    axr(OFF_SFAIL, d, r);
    chk("sensor_fail", 32'h1 << p, d);
    axr(OFF_ACTIVE, d, r);
    chk("active", {24'h0, act}, d);
    sens_set <= 8'hff;
    cyc(ST);
    axw(OFF_CTRL, 32'h1 << CTRL_RST_BIT, r);
    cyc(4);
    act = 8'h0;
    un = 8'h0;
    co();
    $display("test sensor done");
    test_set <= 1'b1;
    cyc(ST);
    @(negedge clk);
    chk("self_test_pin", {11'h0, 16'hffff, 5'h10}, {11'h0, lamp, alarm_out});
    test_set <= 1'b0;
    axw(OFF_CTRL, 32'h1 << CTRL_TEST_BIT, r);
    cyc(ST);
    @(negedge clk);
    chk("self_test_reg", {11'h0, 16'hffff, 5'h10}, {11'h0, lamp, alarm_out});
    axw(OFF_CTRL, 32'h0, r);
    cyc(4);
    co();
    axr(8'h18, d, r);
    chk("unmapped_read", {30'h0, RESP_SLVERR}, {30'h0, r});
    axw(8'h18, 32'h0, r);
    chk("unmapped_write", {30'h0, RESP_SLVERR}, {30'h0, r});
    // Byte 0 not enabled: class register must keep its value
    @(posedge clk);
    wstrb <= 4'he;
    axw(OFF_CLASS, 32'h0, r);
    wstrb <= 4'hf;
    axr(OFF_CLASS, d, r);
    chk("class_strb", {24'h0, CLASS_RST}, d);
    $display("test test_and_bus done");
    repeat (3)
    begin
      cls = 8'($urandom);
      axw(OFF_CLASS, {24'h0, cls}, r);
      act = 8'($urandom);
      un = act;
      fault_set <= act;
      cyc(ST);
      co();
      cl();
      fault_set <= 8'h00;
      press(1'b1);
      un = 8'h0;
      press(1'b0);
      act = 8'h0;
      co();
    end
    $display("test random done");
    results();
  end
endmodule : testbench
`default_nettype wire
